// ==== inc/adcc_cfg.svh ====
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define ADCC_ADDR_W 5
`define ADCC_OFS_CTRL 5'h00
`define ADCC_OFS_STATUS 5'h04
`define ADCC_OFS_IRQ_STAT 5'h08
`define ADCC_OFS_IRQ_EN 5'h0C
`define ADCC_OFS_IRQ_CLR 5'h10

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define ADCC_CTRL_W 9
`define ADCC_CTRL_RST 9'h000
`define ADCC_IRQ_W 2
`define ADCC_IRQ_RST 2'h0
`define ADCC_EV_DONE 0
`define ADCC_EV_REFUSED 1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ADCC_CLK_MHZ 40
`define ADCC_CONV_EDGES 37
`define ADCC_INT_CONV_NS 1260
`define ADCC_INT_CONV_CYC ((`ADCC_INT_CONV_NS * `ADCC_CLK_MHZ) / 1000)
`define ADCC_EXT_MIN_NS 925
`define ADCC_EXT_MIN_CYC ((`ADCC_EXT_MIN_NS * `ADCC_CLK_MHZ + 999) / 1000)

`endif

// ==== inc/adcc_pkg.sv ====
package adcc_pkg;

  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b00,
    ADCC_HELD = 2'b01,
    ADCC_CONV = 2'b10,
    ADCC_LOAD = 2'b11
  } adcc_pair_state_t;

  typedef struct packed {
    logic [2:0] span_wide;
    logic ref_level_bit;
    logic clock_source_bit;
    logic flag_polarity_bit;
    logic done_mode;
    logic seq_mode;
    logic sw_mode;
  } adcc_ctrl_t;

  typedef struct packed {
    logic refused;
    logic done;
  } adcc_irq_t;

endpackage

// ==== rtl/adcc_conv_ctrl.sv ====
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "adcc_cfg.svh"
module adcc_conv_ctrl
  import adcc_pkg::*;
#(
  parameter int PAIRS = 3,
  parameter int RESULT_W = 16,
  parameter int CONV_EDGES = `ADCC_CONV_EDGES,
  parameter int INT_CONV_CYC = `ADCC_INT_CONV_CYC,
  parameter int EXT_MIN_CYC = `ADCC_EXT_MIN_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [`ADCC_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [PAIRS-1:0] pair_sample_start,
  input wire logic external_conv_clock,
  input wire logic range_pin,
  output logic [PAIRS-1:0] pair_hold,
  output logic [PAIRS-1:0] pair_load,
  output logic [PAIRS-1:0] pair_span_wide,
  output logic ref_level_out,
  output logic ext_clock_selected,
  output logic busy_flag_out,
  output logic irq
);

  localparam int CW = $clog2(INT_CONV_CYC + CONV_EDGES + 1);
  localparam int EW = $clog2(CONV_EDGES + 1);
  localparam int XW = $clog2(EXT_MIN_CYC + 1);
  localparam logic [CW-1:0] ACC_STEP = CW'(CONV_EDGES);
  localparam logic [CW-1:0] ACC_WRAP = CW'(INT_CONV_CYC);
  localparam logic [EW-1:0] EDGE_LAST = EW'(CONV_EDGES);
  localparam logic [XW-1:0] EXT_MIN = XW'(EXT_MIN_CYC);

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  adcc_ctrl_t ctrl_q;
  adcc_irq_t irq_stat_q;
  adcc_irq_t irq_en_q;
  logic wait_q;
  logic acc_wr;
  logic [31:0] be_mask;
  logic [31:0] rd_d;
  logic range_q;
  logic busy_q;
  logic done_q;
  adcc_pair_state_t st_q [PAIRS];

  assign acc_wr = write & ~wait_q;
  assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                    {8{byteenable[1]}}, {8{byteenable[0]}}};

  // The slave inserts one wait state, then answers for exactly one cycle.
  always_ff @(posedge clock) begin
    if (rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~((read | write) & wait_q);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q <= `ADCC_CTRL_RST;
    end else if (acc_wr && address == `ADCC_OFS_CTRL) begin
      ctrl_q <= (ctrl_q & ~be_mask[`ADCC_CTRL_W-1:0]) |
                (writedata[`ADCC_CTRL_W-1:0] & be_mask[`ADCC_CTRL_W-1:0]);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_en_q <= `ADCC_IRQ_RST;
    end else if (acc_wr && address == `ADCC_OFS_IRQ_EN && byteenable[0]) begin
      irq_en_q <= writedata[`ADCC_IRQ_W-1:0];
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (address)
      `ADCC_OFS_CTRL: rd_d[`ADCC_CTRL_W-1:0] = ctrl_q;
      `ADCC_OFS_STATUS: rd_d[PAIRS+2:0] = {range_q, done_q, busy_q, pair_hold};
      `ADCC_OFS_IRQ_STAT: rd_d[`ADCC_IRQ_W-1:0] = irq_stat_q;
      `ADCC_OFS_IRQ_EN: rd_d[`ADCC_IRQ_W-1:0] = irq_en_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read && wait_q) begin
      readdata <= rd_d;
    end
  end

  assign waitrequest = wait_q;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic use_ext;
  logic sw_all;

  assign use_ext = ctrl_q.sw_mode & ctrl_q.clock_source_bit;
  assign sw_all = ctrl_q.sw_mode & ~ctrl_q.seq_mode;

  always_ff @(posedge clock) begin
    if (rst) begin
      ext_clock_selected <= 1'b0;
      ref_level_out <= 1'b0;
    end else begin
      ext_clock_selected <= use_ext;
      ref_level_out <= ctrl_q.ref_level_bit;
    end
  end

  // Span: high selects plus/minus four times the reference.
  always_ff @(posedge clock) begin
    if (rst) begin
      pair_span_wide <= '0;
    end else if (ctrl_q.sw_mode) begin
      pair_span_wide <= ctrl_q.span_wide[PAIRS-1:0];
    end else begin
      pair_span_wide <= {PAIRS{range_q}};
    end
  end

  // ----------------------------------------------------------------
  // Conversion clock edges
  // ----------------------------------------------------------------
  logic [CW-1:0] acc_q;
  logic [CW-1:0] acc_sum;
  logic int_tick_q;
  logic ext_q;
  logic ext_prev_q;
  logic conv_tick;

  // Internal clock: 37 half-period edges spread over a 50-cycle window (1.25 us at 40 MHz).
  assign acc_sum = acc_q + ACC_STEP;

  always_ff @(posedge clock) begin
    if (rst) begin
      acc_q <= '0;
      int_tick_q <= 1'b0;
    end else if (acc_sum >= ACC_WRAP) begin
      acc_q <= acc_sum - ACC_WRAP;
      int_tick_q <= 1'b1;
    end else begin
      acc_q <= acc_sum;
      int_tick_q <= 1'b0;
    end
  end

  // Both edges of the external clock count; a clock parked low gives no edges.
  always_ff @(posedge clock) begin
    if (rst) begin
      ext_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_q <= external_conv_clock;
      ext_prev_q <= ext_q;
    end
  end

  assign conv_tick = use_ext ? (ext_q ^ ext_prev_q) : int_tick_q;

  // ----------------------------------------------------------------
  // Sample start detection
  // ----------------------------------------------------------------
  logic [PAIRS-1:0] start_prev_q;
  logic [PAIRS-1:0] start_rise;
  logic [PAIRS-1:0] trig;
  logic [PAIRS-1:0] accept;
  logic [PAIRS-1:0] refuse;
  logic [PAIRS-1:0] idle;
  logic [PAIRS-1:0] loading;

  always_ff @(posedge clock) begin
    if (rst) begin
      start_prev_q <= '0;
    end else begin
      start_prev_q <= pair_sample_start;
    end
  end

  assign start_rise = pair_sample_start & ~start_prev_q;
  assign trig = sw_all ? {PAIRS{start_rise[0]}} : start_rise;
  assign accept = trig & idle;
  assign refuse = trig & ~idle;

  // ----------------------------------------------------------------
  // Per-pair conversion sequencers
  // ----------------------------------------------------------------
  for (genvar i = 0; i < PAIRS; i++) begin : g_pair
    logic [EW-1:0] edges_q;
    logic [XW-1:0] elapsed_q;
    logic min_met;

    assign idle[i] = (st_q[i] == ADCC_IDLE);
    assign loading[i] = (st_q[i] == ADCC_LOAD);
    assign min_met = ~use_ext | (elapsed_q >= EXT_MIN);

    // Both inputs of the pair share this sequencer, so they convert in step.
    always_ff @(posedge clock) begin
      if (rst) begin
        st_q[i] <= ADCC_IDLE;
      end else begin
        unique case (st_q[i])
          ADCC_IDLE: begin
            if (accept[i]) begin
              st_q[i] <= ADCC_HELD;
            end
          end
          ADCC_HELD: begin
            if (conv_tick) begin
              st_q[i] <= ADCC_CONV;
            end
          end
          ADCC_CONV: begin
            if (edges_q == EDGE_LAST && min_met) begin
              st_q[i] <= ADCC_LOAD;
            end
          end
          ADCC_LOAD: begin
            st_q[i] <= ADCC_IDLE;
          end
        endcase
      end
    end

    always_ff @(posedge clock) begin
      if (rst) begin
        edges_q <= '0;
      end else if (st_q[i] != ADCC_CONV) begin
        edges_q <= '0;
      end else if (conv_tick && edges_q != EDGE_LAST) begin
        edges_q <= edges_q + EW'(1);
      end
    end

    always_ff @(posedge clock) begin
      if (rst) begin
        elapsed_q <= '0;
      end else if (st_q[i] == ADCC_IDLE) begin
        elapsed_q <= '0;
      end else if (elapsed_q != EXT_MIN) begin
        elapsed_q <= elapsed_q + XW'(1);
      end
    end

    always_ff @(posedge clock) begin
      if (rst) begin
        pair_hold[i] <= 1'b0;
        pair_load[i] <= 1'b0;
      end else begin
        pair_hold[i] <= (st_q[i] == ADCC_HELD) || (st_q[i] == ADCC_CONV) || accept[i];
        pair_load[i] <= (st_q[i] == ADCC_CONV) && edges_q == EDGE_LAST && min_met;
      end
    end
  end

  // ----------------------------------------------------------------
  // Busy and conversion-done
  // ----------------------------------------------------------------
  logic busy_d;
  logic done_d;
  logic last_load;

  // Last load: every pair still active is in its load cycle and no start is accepted in that cycle.
  assign last_load = (|loading) && ((~idle & ~loading) == '0) && accept == '0;

  always_comb begin
    busy_d = busy_q;
    if (|accept) begin
      busy_d = 1'b1;
    end else if (last_load) begin
      busy_d = 1'b0;
    end else if (ctrl_q.seq_mode && |loading) begin
      busy_d = 1'b0;
    end else if (|(~idle)) begin
      busy_d = 1'b1;
    end
  end

  // Done stays up across data reads and falls only at the next accepted start.
  always_comb begin
    done_d = done_q;
    if (last_load) begin
      done_d = 1'b1;
    end else if (|accept) begin
      done_d = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      busy_flag_out <= 1'b0;
    end else begin
      busy_flag_out <= (ctrl_q.done_mode ? done_d : busy_d) ^ ctrl_q.flag_polarity_bit;
    end
  end

  // Range pin is caught as busy falls, only with normal flag polarity.
  always_ff @(posedge clock) begin
    if (rst) begin
      range_q <= 1'b0;
    end else if (busy_q && !busy_d && !ctrl_q.flag_polarity_bit) begin
      range_q <= range_pin;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  adcc_irq_t ev;
  adcc_irq_t clr;

  assign ev.done = last_load;
  assign ev.refused = |refuse;
  assign clr = (acc_wr && address == `ADCC_OFS_IRQ_CLR && byteenable[0]) ?
               adcc_irq_t'(writedata[`ADCC_IRQ_W-1:0]) : adcc_irq_t'(`ADCC_IRQ_RST);

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_stat_q <= `ADCC_IRQ_RST;
    end else begin
      irq_stat_q <= (irq_stat_q & ~clr) | ev;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_stat_q & ~clr) | ev) & irq_en_q);
    end
  end

endmodule // adcc_conv_ctrl

// ==== sim/adcc_conv_ctrl_assertions.sv ====
`timescale 1ns/1ps
module adcc_conv_ctrl_chk #(
  parameter int PAIRS = 3,
  parameter int INT_CONV_CYC = 50,
  parameter int EXT_MIN_CYC = 37
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic [PAIRS-1:0] pair_sample_start,
  input wire logic [PAIRS-1:0] pair_hold,
  input wire logic [PAIRS-1:0] pair_load,
  input wire logic ext_clock_selected
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [15:0] held_q;
  // Counts how many cycles pair A has been held so far.
  always_ff @(posedge clock) begin
    if (rst || !pair_hold[0]) begin
      held_q <= 16'h0000;
    end else if (held_q != 16'hFFFF) begin
      held_q <= held_q + 16'h0001;
    end
  end
  sequence s_a_start;
    $rose(pair_sample_start[0]) && pair_hold == '0 && pair_load == '0;
  endsequence
  sequence s_a_end;
    $fell(pair_hold[0]);
  endsequence
  property p_a_start;
    s_a_start |=> pair_hold[0];
  endproperty
  property p_a_end;
    s_a_end |-> $past(pair_load[0]);
  endproperty
  property p_int_len;
    s_a_end and !ext_clock_selected |->
      held_q >= INT_CONV_CYC - 3 && held_q <= INT_CONV_CYC + 4;
  endproperty
  property p_ext_len;
    s_a_end and ext_clock_selected |-> held_q >= EXT_MIN_CYC;
  endproperty
  property p_a_cause;
    $rose(pair_hold[0]) |-> $past(pair_sample_start[0]) && !$past(pair_sample_start[0], 2);
  endproperty
  property p_b_cause;
    $rose(pair_hold[1]) |-> $past(pair_sample_start[1] || pair_sample_start[0]);
  endproperty
  property p_load_pulse;
    pair_load[0] |=> !pair_load[0];
  endproperty
  property p_wait_answer;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  property p_wait_stand;
    !waitrequest |=> waitrequest;
  endproperty
  a_a_start: assert property (p_a_start)
    else $error("pair A not held after start");
  a_a_end: assert property (p_a_end)
    else $error("pair A released without load");
  a_int_len: assert property (p_int_len)
    else $error("internal conversion length wrong");
  a_ext_len: assert property (p_ext_len)
    else $error("external conversion too short");
  a_a_cause: assert property (p_a_cause)
    else $error("pair A held without start edge");
  a_b_cause: assert property (p_b_cause)
    else $error("pair B held without start");
  a_load_pulse: assert property (p_load_pulse)
    else $error("load pulse longer than one cycle");
  a_wait_answer: assert property (p_wait_answer)
    else $error("no answer after one wait state");
  a_wait_stand: assert property (p_wait_stand)
    else $error("waitrequest low for two cycles");
endmodule // adcc_conv_ctrl_chk

// ==== sim/adcc_conv_ctrl_tb.sv ====
`timescale 1ns/1ps
module adcc_conv_ctrl_tb import adcc_pkg::*;;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic range_pin = 1'b0;
  logic go = 1'b0;
  logic force_busy = 1'b0;
  logic ext_run = 1'b0;
  logic [2:0] mask = 3'h0;
  logic [3:0] half = 4'h1;
  logic [31:0] seed = 32'h0000BF35;
  logic [31:0] readdata, q;
  logic waitrequest, external_conv_clock, ref_level_out, ext_clock_selected, busy_flag_out, irq;
  logic [2:0] pair_sample_start, pair_hold, pair_load, pair_span_wide;
  int err_total = 0;
  int checks = 0;
  int i, n;
  adcc_ctrl_t c;
  always #12.5 clock = ~clock;
  adcc_conv_ctrl uut (.clock, .rst, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .pair_sample_start, .external_conv_clock, .range_pin,
    .pair_hold, .pair_load, .pair_span_wide, .ref_level_out, .ext_clock_selected,
    .busy_flag_out, .irq);
  adcc_host_model host (.clock, .rst, .go, .mask, .force_busy, .pair_hold, .ext_run,
    .half, .pair_sample_start, .external_conv_clock);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= d;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic start(input logic [2:0] m, input logic f);
    @(posedge clock);
    go <= 1'b1;
    mask <= m;
    force_busy <= f;
    @(posedge clock);
    go <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    while ((pair_hold !== 3'h0 || pair_load !== 3'h0) && k < 3000) begin
      @(posedge clock);
      k++;
    end
    if (k >= 3000) err_total++;
    repeat (3) @(posedge clock);
  endtask
  initial begin
    #500000;
    err_total++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    bus(1'b0, 5'h00, 32'h0);
    chk(32'h0, q);
    bus(1'b0, 5'h0C, 32'h0);
    chk(32'h0, q);
    bus(1'b0, 5'h14, 32'h0);
    chk(32'h0, q);
    for (i = 0; i < 6; i++) begin
      seed = xs(seed);
      c = adcc_ctrl_t'(seed[8:0]);
      c.sw_mode = 1'b1;
      c.seq_mode = 1'b0;
      c.done_mode = 1'b0;
      bus(1'b1, 5'h00, 32'(c));
      bus(1'b0, 5'h00, 32'h0);
      chk(32'(c), q);
      chk(32'(c.span_wide), 32'(pair_span_wide));
      chk(32'(c.ref_level_bit), 32'(ref_level_out));
      chk(32'(c.clock_source_bit), 32'(ext_clock_selected));
      chk(32'(c.flag_polarity_bit), 32'(busy_flag_out));
    end
    bus(1'b1, 5'h00, 32'h10);
    bus(1'b1, 5'h0C, 32'h3);
    chk(32'h0, 32'(ext_clock_selected));
    for (i = 1; i < 8; i++) begin
      seed = xs(seed);
      range_pin <= seed[0];
      start(3'(i), 1'b0);
      bus(1'b0, 5'h04, 32'h0);
      chk(32'(i) | 32'h8, q & 32'hF);
      chk(32'h1, 32'(busy_flag_out));
      wait_idle();
      chk(32'h0, 32'(busy_flag_out));
      bus(1'b0, 5'h04, 32'h0);
      chk({26'h0, seed[0], 5'h10}, q & 32'h3F);
      chk(32'h1, 32'(irq));
      bus(1'b1, 5'h10, 32'h1);
      repeat (2) @(posedge clock);
      chk(32'h0, 32'(irq));
    end
    bus(1'b1, 5'h00, 32'h1);
    start(3'h6, 1'b0);
    chk(32'h0, 32'(pair_hold));
    start(3'h1, 1'b0);
    chk(32'h7, 32'(pair_hold));
    wait_idle();
    bus(1'b1, 5'h00, 32'h3);
    start(3'h1, 1'b0);
    start(3'h2, 1'b0);
    n = 0;
    while (pair_hold[1] === 1'b1) begin
      @(posedge clock);
      if (pair_hold[1] === 1'b1 && busy_flag_out === 1'b0) n++;
    end
    chk(32'h1, 32'(n));
    wait_idle();
    bus(1'b1, 5'h00, 32'h0);
    bus(1'b1, 5'h10, 32'h3);
    start(3'h1, 1'b0);
    start(3'h1, 1'b1);
    bus(1'b0, 5'h08, 32'h0);
    chk(32'h2, q);
    chk(32'h1, 32'(irq));
    bus(1'b1, 5'h0C, 32'h1);
    repeat (2) @(posedge clock);
    chk(32'h0, 32'(irq));
    bus(1'b1, 5'h10, 32'h2);
    wait_idle();
    bus(1'b0, 5'h08, 32'h0);
    chk(32'h1, q);
    chk(32'h1, 32'(irq));
    bus(1'b1, 5'h00, 32'h8);
    start(3'h2, 1'b0);
    chk(32'h0, 32'(busy_flag_out));
    wait_idle();
    chk(32'h1, 32'(busy_flag_out));
    bus(1'b1, 5'h00, 32'h4);
    start(3'h4, 1'b0);
    wait_idle();
    bus(1'b0, 5'h04, 32'h0);
    chk(32'h1, 32'(busy_flag_out));
    for (i = 0; i < 2; i++) begin
      seed = xs(seed);
      half <= (i == 0) ? 4'h1 : 4'(2 + seed[1:0]);
      ext_run <= 1'b1;
      bus(1'b1, 5'h00, 32'h11);
      start(3'h1, 1'b0);
      n = 0;
      while (pair_hold[0] === 1'b1 && n < 1000) begin
        @(posedge clock);
        n++;
      end
      chk(32'h1, 32'(n >= 37 * half - 3 && n <= 39 * half + 4));
      wait_idle();
      chk(32'h0, 32'(external_conv_clock));
    end
    finish_test();
  end
endmodule // adcc_conv_ctrl_tb
bind adcc_conv_ctrl adcc_conv_ctrl_chk #(.PAIRS(PAIRS), .INT_CONV_CYC(INT_CONV_CYC),
  .EXT_MIN_CYC(EXT_MIN_CYC)) u_chk (.clock, .rst, .read, .write, .waitrequest,
  .pair_sample_start, .pair_hold, .pair_load, .ext_clock_selected);

// ==== sim/adcc_host_model.sv ====
`timescale 1ns/1ps
module adcc_host_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic go,
  input wire logic [2:0] mask,
  input wire logic force_busy,
  input wire logic [2:0] pair_hold,
  input wire logic ext_run,
  input wire logic [3:0] half,
  output logic [2:0] pair_sample_start,
  output logic external_conv_clock
);
  logic [3:0] tick_q;
  // A converting pair gets no new start unless a refusal is wanted.
  always_ff @(posedge clock) begin
    if (rst || !go) begin
      pair_sample_start <= 3'h0;
    end else begin
      pair_sample_start <= mask & (force_busy ? 3'h7 : ~pair_hold);
    end
  end
  // The conversion clock runs only during a conversion and rests low otherwise.
  always_ff @(posedge clock) begin
    if (rst || !ext_run || pair_hold == 3'h0) begin
      tick_q <= 4'h0;
      external_conv_clock <= 1'b0;
    end else if (tick_q + 4'h1 >= half) begin
      tick_q <= 4'h0;
      external_conv_clock <= ~external_conv_clock;
    end else begin
      tick_q <= tick_q + 4'h1;
    end
  end
endmodule // adcc_host_model
